// ===== core/phy_bringup_consts.vh
// Constants for the management-side bring-up register bank.
// Assumes includers use these names only; no logic lives here.
`ifndef PHY_BRINGUP_CONSTS_VH
`define PHY_BRINGUP_CONSTS_VH

// Clause 22 register addresses
`define C22_CTRL_REG        5'h00
`define ID_HIGH_REG         16'h0002
`define ID_LOW_REG          16'h0003
// Clause 45 device addresses
`define DEV_PMA             5'h01
`define DEV_AN              5'h07
`define DEV_VEND1           5'h1E
`define DEV_VEND2           5'h1F
// Clause 45 register addresses outside the identifier pair
`define CTRL_REG            16'h0010
`define STATUS_REG          16'h0011
`define CAP_REG             16'h0012
`define ADV_REG             16'h0203
// Control register fields
`define CTRL_SOFT_RESET_BIT 15
`define CTRL_AN_EN_BIT      12
`define CTRL_PD_BIT         11
// Status register fields
`define STAT_READY_BIT      0
`define STAT_PD_BIT         1
// Capability and advertisement fields
`define CAP_HI_BIT          13
`define ADV_HI_ABLE_BIT     13
`define ADV_HI_REQ_BIT      12
// Reset values
`define AN_EN_RESET         1'b1
// Frame timing in MDC bits
`define PREAMBLE_BITS       6'd32
`define HDR_LAST_BIT        5'd13
`define TA_FIRST_BIT        5'd14
`define FRAME_LAST_BIT      5'd31
// Start-up sequence length in ref_clk cycles
`define STARTUP_CYCLES      64

`endif

// ===== core/phy_bringup_regs.v
// MDIO slave and bring-up register bank: identifiers, power-down, transmit level.
// Assumes mdc/mdio and straps come from pins and are sampled on ref_clk (25 MHz).
//
// Function
// R01 - Media converter only honoured in RMII mode
// R02 - Stay powered down after reset until host; code does so only when powerdown_after_reset_strap is low
// R03 - Writing zero to power-down bit wakes device
// R04 - Identifiers at 0x2/0x3, C22, C45, MMD 0x1F
// R05 - High identifier word is fixed vendor bits
// R06 - Low word: vendor bits, model, revision
// R07 - Identifiers read zero until start-up completes
// R08 - Read-only system ready flag after start-up
// R09 - Read-only power-down flag, follows strap
// R10 - Autonegotiation enabled by default after reset
// R11 - High-swing advertisement accepted only when capable
// R12 - Host request bit prefers high or low swing
// R13 - Without advertised ability, resolve only low swing
// R14 - Capability from strap; low strap enables it
// R15 - Capability reads one when both levels supported
// R16 - Level used comes from autonegotiation result
// R17 - Writes to read-only bits are ignored
`timescale 1ns/1ps
`default_nettype none
`include "phy_bringup_consts.vh"

module phy_bringup_regs #(
  parameter [15:0] VENDOR_ID_UPPER  = 16'h1234, // Arbitrary value
  parameter [5:0]  VENDOR_ID_LOWER  = 6'h15,    // Arbitrary value
  parameter [6:0]  MODEL_NUMBER     = 7'h05,    // Arbitrary value
  parameter [6:0]  REVISION_NUMBER  = 7'h02,    // Arbitrary value
  parameter integer STARTUP_CYCLES  = `STARTUP_CYCLES
) (
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire       mdc,
  input  wire       mdio_in,
  output reg        mdio_out,
  output reg        mdio_oe,
  input  wire [4:0] phy_addr,
  input  wire       powerdown_after_reset_strap,
  input  wire       low_swing_only_strap,
  input  wire       media_convert_strap,
  input  wire [1:0] mac_if_select,
  input  wire       an_done,
  input  wire       an_resolved_high_swing,
  output reg        system_ready,
  output reg        powered_down,
  output reg        an_enable,
  output reg        an_run,
  output reg        adv_high_swing_ability,
  output reg        adv_high_swing_request,
  output reg        high_swing_capable,
  output reg        media_convert_en,
  output reg        tx_high_swing
);

  localparam [2:0] ST_PRE   = 3'd0;
  localparam [2:0] ST_HDR   = 3'd1;
  localparam [2:0] ST_READ  = 3'd2;
  localparam [2:0] ST_WRITE = 3'd3;
  localparam [2:0] ST_SKIP  = 3'd4;

  localparam [2:0] SEL_NONE = 3'd0;
  localparam [2:0] SEL_CTRL = 3'd1;
  localparam [2:0] SEL_IDH  = 3'd2;
  localparam [2:0] SEL_IDL  = 3'd3;
  localparam [2:0] SEL_STAT = 3'd4;
  localparam [2:0] SEL_CAP  = 3'd5;
  localparam [2:0] SEL_ADV  = 3'd6;

  // Two-flop synchronisers; logic reads stage 2, and mdc_prev for the mdc edge
  reg        mdc_s1;
  reg        mdc_s2;
  reg        mdc_prev;
  reg        mdio_s1;
  reg        mdio_s2;
  reg [4:0]  strap_s1;
  reg [4:0]  strap_s2;

  reg [2:0]  state;
  reg [4:0]  bit_cnt;
  reg [5:0]  pre_cnt;
  reg [15:0] shift;
  reg        is_c45;
  reg [1:0]  opcode;
  reg [4:0]  devad;
  reg [15:0] addr45;
  reg [15:0] rd_shift;
  reg [15:0] start_cnt;
  reg        pd_ctrl;

  wire        mdc_rise = mdc_s2 & ~mdc_prev;
  wire        bit_in   = mdio_s2;
  wire [13:0] hdr      = {shift[12:0], bit_in};
  wire [15:0] word_in  = {shift[14:0], bit_in};
  wire [2:0]  cur_sel  = reg_sel(is_c45, devad, is_c45 ? addr45 : {11'h000, devad});

  function [2:0] reg_sel;
    input        c45;
    input [4:0]  dev;
    input [15:0] ra;
    begin
      reg_sel = SEL_NONE;
      if (!c45) begin
        if (ra == {11'h000, `C22_CTRL_REG}) reg_sel = SEL_CTRL;
        else if (ra == `ID_HIGH_REG)        reg_sel = SEL_IDH; // R04
        else if (ra == `ID_LOW_REG)         reg_sel = SEL_IDL; // R04
      end else if ((dev == `DEV_PMA || dev == `DEV_VEND2) && ra == `ID_HIGH_REG) begin
        reg_sel = SEL_IDH; // R04
      end else if ((dev == `DEV_PMA || dev == `DEV_VEND2) && ra == `ID_LOW_REG) begin
        reg_sel = SEL_IDL; // R04
      end else if (dev == `DEV_VEND1 && ra == `CTRL_REG) begin
        reg_sel = SEL_CTRL;
      end else if (dev == `DEV_VEND1 && ra == `STATUS_REG) begin
        reg_sel = SEL_STAT;
      end else if (dev == `DEV_PMA && ra == `CAP_REG) begin
        reg_sel = SEL_CAP;
      end else if (dev == `DEV_AN && ra == `ADV_REG) begin
        reg_sel = SEL_ADV;
      end
    end
  endfunction

  reg [15:0] rd_val;
  always @* begin
    rd_val = 16'h0000;
    case (cur_sel)
      SEL_CTRL: begin
        rd_val[`CTRL_AN_EN_BIT] = an_enable;
        rd_val[`CTRL_PD_BIT]    = pd_ctrl;
      end
      // Zero until start-up is over so the host can poll for it
      SEL_IDH: rd_val = system_ready ? VENDOR_ID_UPPER : 16'h0000; // R05 R07
      SEL_IDL: rd_val = system_ready ? {VENDOR_ID_LOWER, MODEL_NUMBER[5:0],
                                        REVISION_NUMBER[3:0]} : 16'h0000; // R06 R07
      SEL_STAT: begin
        rd_val[`STAT_READY_BIT] = system_ready; // R08
        rd_val[`STAT_PD_BIT]    = pd_ctrl;      // R09
      end
      SEL_CAP: rd_val[`CAP_HI_BIT] = high_swing_capable; // R15
      SEL_ADV: begin
        rd_val[`ADV_HI_ABLE_BIT] = adv_high_swing_ability;
        rd_val[`ADV_HI_REQ_BIT]  = adv_high_swing_request;
      end
      default: rd_val = 16'h0000;
    endcase
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Idle-high level, so a release with mdc resting high gives no false edge
      mdc_s1   <= 1'b1;
      mdc_s2   <= 1'b1;
      mdc_prev <= 1'b1;
      mdio_s1  <= 1'b1;
      mdio_s2  <= 1'b1;
      strap_s1 <= 5'h00;
      strap_s2 <= 5'h00;
    end else begin
      mdc_s1   <= mdc;
      mdc_s2   <= mdc_s1;
      mdc_prev <= mdc_s2;
      mdio_s1  <= mdio_in;
      mdio_s2  <= mdio_s1;
      strap_s1 <= {powerdown_after_reset_strap, low_swing_only_strap,
                   media_convert_strap, mac_if_select};
      strap_s2 <= strap_s1;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state                  <= ST_PRE;
      bit_cnt                <= 5'd0;
      pre_cnt                <= 6'd0;
      shift                  <= 16'h0000;
      is_c45                 <= 1'b0;
      opcode                 <= 2'b00;
      devad                  <= 5'd0;
      addr45                 <= 16'h0000;
      rd_shift               <= 16'h0000;
      mdio_out               <= 1'b0;
      mdio_oe                <= 1'b0;
      start_cnt              <= 16'h0000;
      system_ready           <= 1'b0;
      pd_ctrl                <= 1'b1;
      powered_down           <= 1'b1;
      an_enable              <= `AN_EN_RESET;
      an_run                 <= 1'b0;
      adv_high_swing_ability <= 1'b0;
      adv_high_swing_request <= 1'b0;
      high_swing_capable     <= 1'b0;
      media_convert_en       <= 1'b0;
      tx_high_swing          <= 1'b0;
    end else begin
      // Straps are caught at the end of start-up, after the synchronisers settle
      if (!system_ready) begin
        if (start_cnt == STARTUP_CYCLES[15:0] - 16'd1) begin
          system_ready           <= 1'b1;                     // R08
          pd_ctrl                <= ~strap_s2[4];             // R02 R09
          high_swing_capable     <= ~strap_s2[3];             // R14 R15
          adv_high_swing_ability <= ~strap_s2[3];
          adv_high_swing_request <= 1'b0;
          media_convert_en       <= strap_s2[2] & (strap_s2[1:0] == 2'b00); // R01
          an_enable              <= `AN_EN_RESET;             // R10
        end else begin
          start_cnt <= start_cnt + 16'd1;
        end
      end
      powered_down <= pd_ctrl;
      an_run       <= system_ready & an_enable & ~pd_ctrl; // R02 R03
      // Level follows the negotiated result, never the advertisement alone
      tx_high_swing <= an_done & an_resolved_high_swing
                       & adv_high_swing_ability & high_swing_capable; // R13 R16

      if (mdc_rise) begin
        bit_cnt <= bit_cnt + 5'd1;
        shift   <= word_in;
        case (state)
          ST_PRE: begin
            bit_cnt <= 5'd1;
            if (bit_in) begin
              if (pre_cnt != `PREAMBLE_BITS) pre_cnt <= pre_cnt + 6'd1;
            end else begin
              pre_cnt <= 6'd0;
              if (pre_cnt == `PREAMBLE_BITS) state <= ST_HDR;
            end
          end
          ST_HDR: begin
            if (bit_cnt == `HDR_LAST_BIT) begin
              is_c45 <= (hdr[13:12] == 2'b00);
              opcode <= hdr[11:10];
              devad  <= hdr[4:0];
              if (hdr[13] || hdr[9:5] != phy_addr) state <= ST_SKIP;
              else if ((hdr[13:12] == 2'b01) ? (hdr[11:10] == 2'b10) : hdr[11])
                state <= ST_READ;
              else state <= ST_WRITE;
            end
          end
          ST_READ: begin
            if (bit_cnt == `TA_FIRST_BIT) begin
              mdio_oe  <= 1'b1;
              mdio_out <= 1'b0;
              rd_shift <= rd_val;
            end else if (bit_cnt == `FRAME_LAST_BIT) begin
              mdio_oe <= 1'b0;
              state   <= ST_PRE;
              // Post-read-increment address step
              if (is_c45 && opcode == 2'b10) addr45 <= addr45 + 16'd1;
            end else begin
              mdio_out <= rd_shift[15];
              rd_shift <= {rd_shift[14:0], 1'b0};
            end
          end
          ST_WRITE: begin
            if (bit_cnt == `FRAME_LAST_BIT) begin
              state <= ST_PRE;
              if (is_c45 && opcode == 2'b00) begin
                addr45 <= word_in;
              end else if (system_ready) begin
                // Other selections are read-only and fall through untouched
                case (cur_sel)
                  SEL_CTRL: begin
                    pd_ctrl   <= word_in[`CTRL_PD_BIT];     // R03
                    an_enable <= word_in[`CTRL_AN_EN_BIT];
                    if (word_in[`CTRL_SOFT_RESET_BIT]) begin
                      // Ready, start-up count and power-down go back to reset values until straps are caught again
                      system_ready <= 1'b0;
                      start_cnt    <= 16'h0000;
                      pd_ctrl      <= 1'b1; // R02
                    end
                  end
                  SEL_ADV: begin
                    adv_high_swing_ability <= word_in[`ADV_HI_ABLE_BIT]
                                              & high_swing_capable; // R11
                    adv_high_swing_request <= word_in[`ADV_HI_REQ_BIT]
                                              & high_swing_capable; // R12
                  end
                  default: ; // R17
                endcase
              end
            end
          end
          ST_SKIP: begin
            if (bit_cnt == `FRAME_LAST_BIT) state <= ST_PRE;
          end
          default: state <= ST_PRE;
        endcase
      end
    end
  end

endmodule // phy_bringup_regs

`default_nettype wire

// ===== verif/mdio_host_model.sv
// Host-side MDIO master: drives mdc and its share of the wire.
// Assumes a pull-up on mdio; device drive seen via mdio_oe.
`timescale 1ns/1ps
`default_nettype none
module mdio_host_model (
  output var  logic mdc,
  output wire logic mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  logic host_oe = 1'b0;
  logic host_bit = 1'b1;
  // Released wire floats to the pull-up level
  assign mdio_in = mdio_oe ? mdio_out : (host_oe ? host_bit : 1'b1);
  initial mdc = 1'b0;
  // Read data is the last 16 rises; mdc rests high between frames
  task automatic frame(input logic [13:0] head, input logic rd, input logic [15:0] wd,
                       output logic [15:0] rdat);
    logic [63:0] bits;
    bits = {32'hFFFFFFFF, head, 2'b10, wd};
    rdat = 16'h0000;
    for (int k = 0; k < 64; k++) begin
      mdc = 1'b0;
      host_oe = !(rd && k > 45);
      host_bit = bits[63-k];
      #160;
      mdc = 1'b1;
      rdat = {rdat[14:0], mdio_in};
      #160;
    end
    host_oe = 1'b0;
  endtask
endmodule // mdio_host_model
`default_nettype wire

// ===== verif/phy_bringup_regs_assertions.sv
// Port checker for the bring-up register bank.
// Assumes one ref_clk domain and straps that move only under reset.
`timescale 1ns/1ps
`default_nettype none
module phy_bringup_regs_chk (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       mdio_out,
  input wire logic       mdio_oe,
  input wire logic       powerdown_after_reset_strap,
  input wire logic       low_swing_only_strap,
  input wire logic       media_convert_strap,
  input wire logic [1:0] mac_if_select,
  input wire logic       an_done,
  input wire logic       an_resolved_high_swing,
  input wire logic       system_ready,
  input wire logic       powered_down,
  input wire logic       an_enable,
  input wire logic       an_run,
  input wire logic       adv_high_swing_ability,
  input wire logic       adv_high_swing_request,
  input wire logic       high_swing_capable,
  input wire logic       media_convert_en,
  input wire logic       tx_high_swing
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  sequence drive_hold;
    !mdio_out ##1 mdio_oe [*8];
  endsequence
  sequence level_cause;
    an_done && an_resolved_high_swing && adv_high_swing_ability && high_swing_capable;
  endsequence
  ta_hold_a: assert property (
    $rose(mdio_oe) |-> drive_hold) else $error("read drive cut short");
  adv_gate_a: assert property (
    system_ready && !high_swing_capable |-> !adv_high_swing_ability && !adv_high_swing_request)
    else $error("advert without capability");
  level_follow_a: assert property (
    level_cause |=> tx_high_swing) else $error("high swing not taken");
  level_cause_a: assert property (
    tx_high_swing |-> $past(an_done && an_resolved_high_swing && adv_high_swing_ability))
    else $error("high swing without cause");
  run_gate_a: assert property (
    an_run |-> !powered_down && $past(system_ready && an_enable)) else $error("run while down");
  media_gate_a: assert property (
    media_convert_en |-> media_convert_strap && mac_if_select == 2'b00)
    else $error("media converter outside rmii");
  cap_strap_a: assert property (
    system_ready |-> high_swing_capable == !low_swing_only_strap) else $error("capability wrong");
  pd_boot_a: assert property (
    $rose(system_ready) |=> powered_down == !powerdown_after_reset_strap)
    else $error("power-down state wrong");
endmodule // phy_bringup_regs_chk
bind phy_bringup_regs phy_bringup_regs_chk i_chk (.ref_clk, .reset_n, .mdio_out, .mdio_oe,
  .powerdown_after_reset_strap, .low_swing_only_strap, .media_convert_strap, .mac_if_select,
  .an_done, .an_resolved_high_swing, .system_ready, .powered_down, .an_enable, .an_run,
  .adv_high_swing_ability, .adv_high_swing_request, .high_swing_capable, .media_convert_en,
  .tx_high_swing);
`default_nettype wire

// ===== verif/test_phy_managed_bringup_config.sv
// Self-checking bench for the MDIO bring-up register bank.
// Assumes mdio_host_model as host and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module test_phy_managed_bringup_config;
  localparam logic [4:0]  PHY = 5'h05;
  localparam logic [15:0] IDH = 16'hA5C3;
  localparam logic [15:0] IDL = {6'h2A, 6'h1B, 4'h5};
  logic ref_clk, reset_n, mdc, mdio_in, mdio_out, mdio_oe, an_done, an_resolved_high_swing;
  logic powerdown_after_reset_strap, low_swing_only_strap, media_convert_strap;
  logic system_ready, powered_down, an_enable, an_run, adv_high_swing_ability;
  logic adv_high_swing_request, high_swing_capable, media_convert_en, tx_high_swing;
  logic [1:0]  mac_if_select;
  logic [15:0] d;
  int          n_mismatch = 0;
  int          total_checks = 0;
  // Arbitrary identity values; long start-up so one read lands before ready
  phy_bringup_regs #(.VENDOR_ID_UPPER(IDH), .VENDOR_ID_LOWER(6'h2A), .MODEL_NUMBER(7'h1B),
    .REVISION_NUMBER(7'h05), .STARTUP_CYCLES(1000)) i_dut (.ref_clk, .reset_n, .mdc,
    .mdio_in, .mdio_out, .mdio_oe, .phy_addr(PHY), .powerdown_after_reset_strap,
    .low_swing_only_strap, .media_convert_strap, .mac_if_select, .an_done,
    .an_resolved_high_swing, .system_ready, .powered_down, .an_enable, .an_run,
    .adv_high_swing_ability, .adv_high_swing_request, .high_swing_capable,
    .media_convert_en, .tx_high_swing);
  mdio_host_model i_host (.mdc, .mdio_in, .mdio_out, .mdio_oe);
  task automatic give_verdict;
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] exp, input logic [15:0] got, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic c22(input logic [4:0] ra, input logic wr, input logic [15:0] wd);
    i_host.frame({2'b01, wr ? 2'b01 : 2'b10, PHY, ra}, !wr, wd, d);
  endtask
  task automatic c45(input logic [4:0] dv, input logic [15:0] ra, input logic wr,
                     input logic [15:0] wd);
    i_host.frame({4'b0000, PHY, dv}, 1'b0, ra, d);
    i_host.frame({2'b00, wr ? 2'b01 : 2'b11, PHY, dv}, !wr, wd, d);
  endtask
  task automatic wait_ready;
    int n;
    for (n = 0; n < 2000 && system_ready !== 1'b1; n++) @(negedge ref_clk);
    if (n == 2000) begin
      chk(1'b1, 1'b0, "ready wait");
      give_verdict;
    end
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic boot(input logic pd, input logic lso, input logic mc, input logic [1:0] mac);
    @(negedge ref_clk);
    reset_n = 1'b0;
    {powerdown_after_reset_strap, low_swing_only_strap, media_convert_strap} = {pd, lso, mc};
    mac_if_select = mac;
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    c22(5'h02, 1'b0, 16'h0000);
    chk(16'h0000, d, "id before ready");
    wait_ready;
  endtask
  task automatic test_ids;
    for (int i = 0; i < 3; i++) begin
      if (i == 0) c22(5'h02, 1'b0, 16'h0000);
      else c45(i == 1 ? 5'h01 : 5'h1F, 16'h0002, 1'b0, 16'h0000);
      chk(IDH, d, "id high");
      if (i == 0) c22(5'h03, 1'b0, 16'h0000);
      else c45(i == 1 ? 5'h01 : 5'h1F, 16'h0003, 1'b0, 16'h0000);
      chk(IDL, d, "id low");
    end
    c22(5'h02, 1'b1, 16'h0000);
    c22(5'h02, 1'b0, 16'h0000);
    chk(IDH, d, "id after write");
    // Another address: nobody drives, so the pull-up reads back
    i_host.frame({2'b01, 2'b10, ~PHY, 5'h02}, 1'b1, 16'h0000, d);
    chk(16'hFFFF, d, "other phy id");
  endtask
  task automatic test_power;
    c45(5'h1E, 16'h0011, 1'b0, 16'h0000);
    chk(16'h0003, d & 16'h0003, "status asleep");
    chk(1'b1, an_enable, "an enable");
    chk(1'b0, an_run, "an run asleep");
    chk(1'b1, media_convert_en, "media rmii");
    c22(5'h00, 1'b1, 16'h1000);
    repeat (8) @(negedge ref_clk);
    chk(1'b1, an_run, "an run awake");
    c45(5'h1E, 16'h0011, 1'b0, 16'h0000);
    chk(16'h0001, d & 16'h0003, "status awake");
    c22(5'h00, 1'b1, 16'h8000);
    c22(5'h02, 1'b0, 16'h0000);
    chk(16'h0000, d, "id in soft reset");
    wait_ready;
    c45(5'h1E, 16'h0011, 1'b0, 16'h0000);
    chk(16'h0003, d & 16'h0003, "status after soft reset");
    chk(1'b0, an_run, "an run after soft reset");
    chk(1'b1, an_enable, "an enable after soft reset");
  endtask
  task automatic test_swing(input logic able);
    c45(5'h01, 16'h0012, 1'b0, 16'h0000);
    chk({2'b00, able, 13'h0000}, d & 16'h2000, "capability");
    c45(5'h07, 16'h0203, 1'b1, 16'h3000);
    c45(5'h07, 16'h0203, 1'b0, 16'h0000);
    chk({2'b00, able, able, 12'h000}, d & 16'h3000, "advert");
    {an_done, an_resolved_high_swing} = 2'b10;
    repeat (4) @(negedge ref_clk);
    chk(1'b0, tx_high_swing, "low resolved");
    an_resolved_high_swing = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(able, tx_high_swing, "high resolved");
    c45(5'h07, 16'h0203, 1'b1, 16'h0000);
    repeat (8) @(negedge ref_clk);
    chk(1'b0, tx_high_swing, "no advert");
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    {reset_n, powerdown_after_reset_strap, low_swing_only_strap, media_convert_strap} = 4'h0;
    {an_done, an_resolved_high_swing, mac_if_select} = 4'h0;
    boot(1'b0, 1'b0, 1'b1, 2'b00);
    test_ids;
    test_power;
    test_swing(1'b1);
    boot(1'b1, 1'b1, 1'b1, 2'b01);
    chk(1'b0, powered_down, "no power-down");
    chk(1'b1, an_run, "an starts");
    chk(1'b0, media_convert_en, "media outside rmii");
    test_swing(1'b0);
    give_verdict;
  end
endmodule // test_phy_managed_bringup_config
`default_nettype wire
